// >>> core/vbat_link_rx.sv
// Link sampler: synchronises the reader-side byte link and finds its rising clock edges
`timescale 1ns/100ps
module vbat_link_rx (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic [7:0] link_data,
    input wire logic link_frame,
    input wire logic link_crc_ok,
    vbat_rx_if.src rx
);
    logic [10:0] s1_q;
    logic [10:0] s2_q;
    logic prev_q;
    logic in_frame_q;
    logic in_frame_d;
    logic byte_stb_q;
    logic byte_stb_d;
    logic [7:0] byte_val_q;
    logic [7:0] byte_val_d;
    logic eof_stb_q;
    logic eof_stb_d;
    logic crc_ok_q;
    logic crc_ok_d;
    logic edge_seen;

    // Only the second stage is looked at; data is held a whole link period
    assign edge_seen = s2_q[10] && !prev_q;

    always_comb begin
        in_frame_d = in_frame_q;
        byte_stb_d = 1'b0;
        byte_val_d = byte_val_q;
        eof_stb_d = 1'b0;
        crc_ok_d = crc_ok_q;
        if (edge_seen) begin
            if (s2_q[9]) begin
                in_frame_d = 1'b1;
                byte_stb_d = 1'b1;
                byte_val_d = s2_q[7:0];
            end else if (in_frame_q) begin
                in_frame_d = 1'b0;
                eof_stb_d = 1'b1;
                crc_ok_d = s2_q[8];
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= 11'h000;
            s2_q <= 11'h000;
            prev_q <= 1'b0;
            in_frame_q <= 1'b0;
            byte_stb_q <= 1'b0;
            byte_val_q <= 8'h00;
            eof_stb_q <= 1'b0;
            crc_ok_q <= 1'b0;
        end else begin
            s1_q <= {link_clk, link_frame, link_crc_ok, link_data};
            s2_q <= s1_q;
            prev_q <= s2_q[10];
            in_frame_q <= in_frame_d;
            byte_stb_q <= byte_stb_d;
            byte_val_q <= byte_val_d;
            eof_stb_q <= eof_stb_d;
            crc_ok_q <= crc_ok_d;
        end
    end

    assign rx.byte_stb = byte_stb_q;
    assign rx.byte_val = byte_val_q;
    assign rx.eof_stb = eof_stb_q;
    assign rx.crc_ok = crc_ok_q;
endmodule : vbat_link_rx

// >>> core/vbat_pkg.sv
// Shared constants and types for the value-block command logic
package vbat_pkg;
    localparam logic [7:0] CMD_DECREMENT = 8'hC0;
    localparam logic [7:0] CMD_INCREMENT = 8'hC1;
    localparam logic [7:0] CMD_RESTORE = 8'hC2;
    localparam logic [7:0] CMD_TRANSFER = 8'hB0;
    localparam logic [7:0] BLOCK_ADDR_MAX = 8'h3F;

    localparam logic [3:0] RSP_ACK = 4'hA;
    // Any value other than the acknowledge code reads as NAK; these two are picked freely
    localparam logic [3:0] RSP_NAK_ARG = 4'h0;
    localparam logic [3:0] RSP_NAK_CHECK = 4'h1;

    localparam logic [3:0] FRAME1_LEN = 4'h4;
    localparam logic [3:0] FRAME2_LEN = 4'h6;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [31:0] HOLD_RESET = 32'h0000_0000;

    localparam int CLK_PERIOD_NS = 8;
    localparam int ACK_DELAY_MIN_NS = 71000;
    localparam int NAK_DELAY_MIN_NS = 71000;
    localparam int RESPONSE_TIMEOUT_VALUE_MS = 5;
    localparam int RESPONSE_TIMEOUT_TRANSFER_MS = 10;
    // Least times round up to whole cycles
    localparam int ACK_DELAY_CYC = (ACK_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NAK_DELAY_CYC = (NAK_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] DLY_MAX = 16'hFFFF;

    typedef enum logic [2:0] {
        VBAT_IDLE = 3'h0,
        VBAT_READ = 3'h1,
        VBAT_DELAY = 3'h3,
        VBAT_PART2 = 3'h2,
        VBAT_WRITE = 3'h6
    } vbat_state_t;
endpackage : vbat_pkg

// >>> core/vbat_rx_if.sv
// Received byte and end-of-frame events from the link sampler
`timescale 1ns/100ps
interface vbat_rx_if;
    logic byte_stb;
    logic [7:0] byte_val;
    logic eof_stb;
    logic crc_ok;

    modport src (output byte_stb, output byte_val, output eof_stb, output crc_ok);
    modport dst (input byte_stb, input byte_val, input eof_stb, input crc_ok);
endinterface : vbat_rx_if

// >>> core/vbat_value_cmd.sv
// Card-side interpreter for increment, decrement, restore and transfer
`timescale 1ns/100ps
module vbat_value_cmd #(
    parameter int ACK_DLY_CYC = vbat_pkg::ACK_DELAY_CYC,
    parameter int NAK_DLY_CYC = vbat_pkg::NAK_DELAY_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic [7:0] link_data,
    input wire logic link_frame,
    input wire logic link_crc_ok,
    output logic tx_valid,
    output logic [3:0] tx_code,
    output logic mem_req,
    output logic mem_we,
    output logic [5:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic [31:0] mem_rdata,
    input wire logic mem_ack
);
    localparam logic [15:0] ACK_LIM = 16'(ACK_DLY_CYC - 1);
    localparam logic [15:0] NAK_LIM = 16'(NAK_DLY_CYC - 1);

    vbat_rx_if rx ();

    vbat_link_rx u_link_rx (
        .clk(clk),
        .resetn(resetn),
        .link_clk(link_clk),
        .link_data(link_data),
        .link_frame(link_frame),
        .link_crc_ok(link_crc_ok),
        .rx(rx)
    );

    function automatic logic vbat_addr_ok(input logic [7:0] addr);
        vbat_addr_ok = addr <= vbat_pkg::BLOCK_ADDR_MAX;
    endfunction : vbat_addr_ok

    // Two's complement wrap on overflow; the value format check lives in the memory side
    function automatic logic [31:0] vbat_apply(
        input logic [7:0] cmd,
        input logic [31:0] src,
        input logic [31:0] opnd
    );
        logic signed [31:0] s;
        logic signed [31:0] o;
        s = $signed(src);
        o = $signed(opnd);
        case (cmd)
            vbat_pkg::CMD_INCREMENT: vbat_apply = 32'(s + o);
            vbat_pkg::CMD_DECREMENT: vbat_apply = 32'(s - o);
            default: vbat_apply = src;
        endcase
    endfunction : vbat_apply

    function automatic logic vbat_is_value_cmd(input logic [7:0] cmd);
        vbat_is_value_cmd = (cmd == vbat_pkg::CMD_INCREMENT) ||
            (cmd == vbat_pkg::CMD_DECREMENT) || (cmd == vbat_pkg::CMD_RESTORE);
    endfunction : vbat_is_value_cmd

    vbat_pkg::vbat_state_t state_q, state_d, after_q, after_d;
    logic [7:0] cmd_q, cmd_d, addr_q, addr_d;
    logic [3:0] cnt_q, cnt_d, rsp_q, rsp_d;
    logic [31:0] opnd_q, opnd_d, src_q, src_d, hold_q, hold_d;
    logic hold_vld_q, hold_vld_d, hold_upd;
    logic [15:0] dly_q, dly_d;
    logic tx_valid_q, tx_valid_d;
    logic [3:0] tx_code_q, tx_code_d;
    logic mem_req_q, mem_req_d, mem_we_q, mem_we_d;
    logic [5:0] mem_addr_q, mem_addr_d;
    logic [31:0] mem_wdata_q, mem_wdata_d;
    logic [15:0] lim;

    assign lim = (rsp_q == vbat_pkg::RSP_ACK) ? ACK_LIM : NAK_LIM;

    always_comb begin
        state_d = state_q;
        after_d = after_q;
        cmd_d = cmd_q;
        addr_d = addr_q;
        cnt_d = cnt_q;
        opnd_d = opnd_q;
        src_d = src_q;
        hold_d = hold_q;
        hold_vld_d = hold_vld_q;
        hold_upd = 1'b0;
        rsp_d = rsp_q;
        dly_d = (dly_q == vbat_pkg::DLY_MAX) ? dly_q : 16'(dly_q + 16'h0001);
        tx_valid_d = 1'b0;
        tx_code_d = tx_code_q;
        mem_req_d = mem_req_q;
        mem_we_d = mem_we_q;
        mem_addr_d = mem_addr_q;
        mem_wdata_d = mem_wdata_q;
        if (rx.byte_stb) begin
            cnt_d = (cnt_q == vbat_pkg::CNT_MAX) ? cnt_q : 4'(cnt_q + 4'h1);
            if (state_q == vbat_pkg::VBAT_IDLE) begin
                if (cnt_q == 4'h0) begin
                    cmd_d = rx.byte_val;
                end
                if (cnt_q == 4'h1) begin
                    addr_d = rx.byte_val;
                end
            end
            // Operand arrives least significant byte first
            if (state_q == vbat_pkg::VBAT_PART2 && cnt_q < 4'h4) begin
                opnd_d[8 * cnt_q[1:0] +: 8] = rx.byte_val;
            end
        end
        if (rx.eof_stb) begin
            cnt_d = 4'h0;
            dly_d = 16'h0000;
        end
        case (state_q)
            vbat_pkg::VBAT_IDLE: begin
                if (rx.eof_stb) begin
                    state_d = vbat_pkg::VBAT_DELAY;
                    after_d = vbat_pkg::VBAT_IDLE;
                    rsp_d = vbat_pkg::RSP_NAK_ARG;
                    if (!rx.crc_ok || cnt_q != vbat_pkg::FRAME1_LEN) begin
                        rsp_d = vbat_pkg::RSP_NAK_CHECK;
                    end else if (vbat_is_value_cmd(cmd_q) && vbat_addr_ok(addr_q)) begin
                        // Source read only; memory is never written here
                        state_d = vbat_pkg::VBAT_READ;
                        after_d = vbat_pkg::VBAT_PART2;
                        rsp_d = vbat_pkg::RSP_ACK;
                        mem_req_d = 1'b1;
                        mem_we_d = 1'b0;
                        mem_addr_d = addr_q[5:0];
                    end else if (cmd_q == vbat_pkg::CMD_TRANSFER && vbat_addr_ok(addr_q) &&
                        hold_vld_q) begin
                        state_d = vbat_pkg::VBAT_WRITE;
                        rsp_d = vbat_pkg::RSP_ACK;
                        mem_req_d = 1'b1;
                        mem_we_d = 1'b1;
                        mem_addr_d = addr_q[5:0];
                        mem_wdata_d = hold_q;
                    end
                end
            end
            vbat_pkg::VBAT_READ: begin
                if (mem_ack) begin
                    mem_req_d = 1'b0;
                    src_d = mem_rdata;
                    state_d = vbat_pkg::VBAT_DELAY;
                end
            end
            vbat_pkg::VBAT_WRITE: begin
                if (mem_ack) begin
                    mem_req_d = 1'b0;
                    mem_we_d = 1'b0;
                    state_d = vbat_pkg::VBAT_DELAY;
                end
            end
            vbat_pkg::VBAT_DELAY: begin
                if (dly_q >= lim) begin
                    tx_valid_d = 1'b1;
                    tx_code_d = rsp_q;
                    state_d = after_q;
                end
            end
            vbat_pkg::VBAT_PART2: begin
                // The reader honours the frame delay before this frame
                if (rx.eof_stb) begin
                    if (rx.crc_ok && cnt_q == vbat_pkg::FRAME2_LEN) begin
                        // Success is silent: the reader sees its time-out
                        hold_d = vbat_apply(cmd_q, src_q, opnd_q);
                        hold_vld_d = 1'b1;
                        hold_upd = 1'b1;
                        state_d = vbat_pkg::VBAT_IDLE;
                    end else begin
                        rsp_d = vbat_pkg::RSP_NAK_CHECK;
                        after_d = vbat_pkg::VBAT_IDLE;
                        state_d = vbat_pkg::VBAT_DELAY;
                    end
                end
            end
            default: begin
                state_d = vbat_pkg::VBAT_IDLE;
                mem_req_d = 1'b0;
                mem_we_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= vbat_pkg::VBAT_IDLE;
            after_q <= vbat_pkg::VBAT_IDLE;
            cmd_q <= 8'h00;
            addr_q <= 8'h00;
            cnt_q <= 4'h0;
            opnd_q <= 32'h0000_0000;
            src_q <= 32'h0000_0000;
            hold_q <= vbat_pkg::HOLD_RESET;
            hold_vld_q <= 1'b0;
            rsp_q <= vbat_pkg::RSP_NAK_ARG;
            dly_q <= vbat_pkg::DLY_MAX;
            tx_valid_q <= 1'b0;
            tx_code_q <= vbat_pkg::RSP_NAK_ARG;
            mem_req_q <= 1'b0;
            mem_we_q <= 1'b0;
            mem_addr_q <= 6'h00;
            mem_wdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            after_q <= after_d;
            cmd_q <= cmd_d;
            addr_q <= addr_d;
            cnt_q <= cnt_d;
            opnd_q <= opnd_d;
            src_q <= src_d;
            hold_q <= hold_d;
            hold_vld_q <= hold_vld_d;
            rsp_q <= rsp_d;
            dly_q <= dly_d;
            tx_valid_q <= tx_valid_d;
            tx_code_q <= tx_code_d;
            mem_req_q <= mem_req_d;
            mem_we_q <= mem_we_d;
            mem_addr_q <= mem_addr_d;
            mem_wdata_q <= mem_wdata_d;
        end
    end

    assign tx_valid = tx_valid_q;
    assign tx_code = tx_code_q;
    assign mem_req = mem_req_q;
    assign mem_we = mem_we_q;
    assign mem_addr = mem_addr_q;
    assign mem_wdata = mem_wdata_q;

    logic part2_done;
    assign part2_done = state_q == vbat_pkg::VBAT_PART2 && rx.eof_stb && rx.crc_ok &&
        cnt_q == vbat_pkg::FRAME2_LEN;

    AST_REPLY_NOT_EARLY: assert property (@(posedge clk) disable iff (!resetn)
        tx_valid_q && tx_code_q == vbat_pkg::RSP_ACK |-> dly_q >= 16'(ACK_DLY_CYC))
        else $error("acknowledge sent before the least reply delay");
    AST_NAK_NOT_EARLY: assert property (@(posedge clk) disable iff (!resetn)
        tx_valid_q && tx_code_q != vbat_pkg::RSP_ACK |-> dly_q >= 16'(NAK_DLY_CYC))
        else $error("nak sent before the least reply delay");
    AST_PART2_SILENT: assert property (@(posedge clk) disable iff (!resetn)
        part2_done |=> (!tx_valid_q && state_q == vbat_pkg::VBAT_IDLE) ##1 !tx_valid_q [*8])
        else $error("reply sent after a good second part");
    AST_INC_SUM: assert property (@(posedge clk) disable iff (!resetn)
        part2_done && cmd_q == vbat_pkg::CMD_INCREMENT |=>
        hold_q == 32'($past(src_q) + $past(opnd_q)))
        else $error("increment result wrong");
    AST_DEC_DIFF: assert property (@(posedge clk) disable iff (!resetn)
        part2_done && cmd_q == vbat_pkg::CMD_DECREMENT |=>
        hold_q == 32'($past(src_q) - $past(opnd_q)))
        else $error("decrement result wrong");
    AST_RESTORE_COPY: assert property (@(posedge clk) disable iff (!resetn)
        part2_done && cmd_q == vbat_pkg::CMD_RESTORE |=> hold_q == $past(src_q))
        else $error("restore result wrong");
    AST_WRITE_ONLY_TRANSFER: assert property (@(posedge clk) disable iff (!resetn)
        mem_req_q && mem_we_q |-> cmd_q == vbat_pkg::CMD_TRANSFER &&
        mem_wdata_q == hold_q && mem_addr_q == addr_q[5:0])
        else $error("memory written by a command other than transfer");
    AST_BAD_ADDR_NAK: assert property (@(posedge clk) disable iff (!resetn)
        state_q == vbat_pkg::VBAT_IDLE && rx.eof_stb && addr_q > vbat_pkg::BLOCK_ADDR_MAX |=>
        state_q == vbat_pkg::VBAT_DELAY && rsp_q != vbat_pkg::RSP_ACK && !mem_req_q)
        else $error("out of range address not refused");
    AST_ACK_OPENS_PART2: assert property (@(posedge clk) disable iff (!resetn)
        state_q == vbat_pkg::VBAT_DELAY && after_q == vbat_pkg::VBAT_PART2 && dly_q >= lim
        |=> tx_valid_q && tx_code_q == vbat_pkg::RSP_ACK && state_q == vbat_pkg::VBAT_PART2)
        else $error("first part acknowledge did not open the second part");
    AST_HOLD_KEPT: assert property (@(posedge clk) disable iff (!resetn)
        !hold_upd |=> $stable(hold_q))
        else $error("holding value changed without a completed command");
    // A stale reset value must never reach a block
    AST_XFER_NEEDS_HOLD: assert property (@(posedge clk) disable iff (!resetn)
        state_q == vbat_pkg::VBAT_IDLE && rx.eof_stb && cmd_q == vbat_pkg::CMD_TRANSFER &&
        !hold_vld_q |=> !mem_req_q && rsp_q != vbat_pkg::RSP_ACK)
        else $error("transfer accepted with no holding value");

    COV_INCREMENT: cover property (@(posedge clk) disable iff (!resetn)
        part2_done && cmd_q == vbat_pkg::CMD_INCREMENT);
    COV_TRANSFER_ACK: cover property (@(posedge clk) disable iff (!resetn)
        tx_valid_q && tx_code_q == vbat_pkg::RSP_ACK && cmd_q == vbat_pkg::CMD_TRANSFER);
    COV_NAK: cover property (@(posedge clk) disable iff (!resetn)
        tx_valid_q && tx_code_q != vbat_pkg::RSP_ACK);
    COV_DECREMENT: cover property (@(posedge clk) disable iff (!resetn)
        part2_done && cmd_q == vbat_pkg::CMD_DECREMENT);
    COV_RESTORE: cover property (@(posedge clk) disable iff (!resetn)
        part2_done && cmd_q == vbat_pkg::CMD_RESTORE);
endmodule : vbat_value_cmd

// >>> verification/value_block_arith_transfer_tb_top.sv
// Testbench for the value-block command logic with reader and memory models
`timescale 1ns/100ps
module value_block_arith_transfer_tb_top;
    localparam int DLY = 20;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic link_clk, link_frame, link_crc_ok;
    logic [7:0] link_data;
    logic tx_valid, mem_req, mem_we;
    logic [3:0] tx_code;
    logic [5:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [31:0] mem_rdata = 32'h0000_0000;
    logic mem_ack = 1'b0;
    logic [31:0] mem [0:63];
    int mem_wr = 0;
    int mem_wait = 0;
    int seed = 3;
    int failures = 0;
    int checks_done = 0;
    logic [31:0] hold_exp;
    logic [7:0] ops [0:2] = '{vbat_pkg::CMD_INCREMENT, vbat_pkg::CMD_DECREMENT,
                              vbat_pkg::CMD_RESTORE};

    always #4 clk = ~clk;

    vbat_value_cmd #(.ACK_DLY_CYC(DLY), .NAK_DLY_CYC(DLY)) dut (
        .clk(clk), .resetn(resetn), .link_clk(link_clk), .link_data(link_data),
        .link_frame(link_frame), .link_crc_ok(link_crc_ok), .tx_valid(tx_valid),
        .tx_code(tx_code), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

    vbat_reader_model rdr (
        .clk(clk), .tx_valid(tx_valid), .tx_code(tx_code), .link_clk(link_clk),
        .link_data(link_data), .link_frame(link_frame), .link_crc_ok(link_crc_ok));

    // Block memory answers after a random wait of zero to three cycles
    always @(negedge clk) begin
        if (mem_ack) begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            mem_wait <= $random(seed) & 3;
        end else if (mem_req === 1'b1) begin
            if (mem_wait > 0) begin
                mem_wait <= mem_wait - 1;
            end else begin
                mem_ack <= 1'b1;
                if (mem_we) begin
                    mem[mem_addr] <= mem_wdata;
                    mem_wr <= mem_wr + 1;
                end else begin
                    mem_rdata <= mem[mem_addr];
                end
            end
        end
    end

    function automatic logic [31:0] calc(logic [7:0] c, logic [31:0] s, logic [31:0] o);
        case (c)
            vbat_pkg::CMD_INCREMENT: return $signed(s) + $signed(o);
            vbat_pkg::CMD_DECREMENT: return $signed(s) - $signed(o);
            default: return s;
        endcase
    endfunction : calc

    task automatic chk_code(input string what, input logic [3:0] exp, input logic [3:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_code

    task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    // One frame, then wait as the reader would for a reply or for silence
    task automatic xchg(input logic [7:0] q [$], input logic ok, input logic rsp,
                        input logic [3:0] code);
        int n0;
        int k;
        n0 = rdr.rsp_cnt;
        rdr.send(q, ok);
        k = 0;
        while (rdr.rsp_cnt == n0 && k < DLY + 200) begin
            @(negedge clk);
            k++;
        end
        chk_val("reply_count", n0 + int'(rsp), rdr.rsp_cnt);
        if (rsp) begin
            chk_code("reply_code", code, rdr.rsp_code);
            chk_code("reply_delay_ok", 4'h1, 4'(rdr.rsp_lat > DLY && rdr.rsp_lat < DLY + 30));
        end
        repeat (20) @(negedge clk);
    endtask : xchg

    task automatic value_op(input logic [7:0] c, input logic [5:0] a, input logic [31:0] o);
        int w0;
        w0 = mem_wr;
        xchg('{c, {2'b00, a}, 8'h5A, 8'hA5}, 1'b1, 1'b1, vbat_pkg::RSP_ACK);
        xchg('{o[7:0], o[15:8], o[23:16], o[31:24], 8'h3C, 8'hC3}, 1'b1, 1'b0, 4'h0);
        chk_val("mem_writes", w0, mem_wr);
        hold_exp = calc(c, mem[a], o);
    endtask : value_op

    task automatic xfer(input logic [7:0] a, input logic [3:0] code);
        xchg('{vbat_pkg::CMD_TRANSFER, a, 8'h11, 8'h22}, 1'b1, 1'b1, code);
        if (code === vbat_pkg::RSP_ACK) begin
            chk_val("dest_block", hold_exp, mem[a[5:0]]);
        end
    endtask : xfer

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish

    // About four times the expected run, still well inside the cycle budget
    initial begin
        #200_000;
        failures++;
        tally_and_finish();
    end

    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = $random(seed);
        end
        mem[1] = 32'h7FFF_FFFF;
        mem[2] = 32'h0000_0000;
        repeat (6) @(negedge clk);
        chk_code("reset_tx", 4'h0, {3'b000, tx_valid});
        chk_code("reset_code", 4'h0, tx_code);
        chk_code("reset_req", 4'h0, {3'b000, mem_req});
        resetn = 1'b1;
        repeat (10) @(negedge clk);
        xfer(8'h05, vbat_pkg::RSP_NAK_ARG);
        // Signed edges: wrap past the top, borrow below zero, negative operand
        value_op(vbat_pkg::CMD_INCREMENT, 6'h01, 32'h0000_0001);
        xfer(8'h3F, vbat_pkg::RSP_ACK);
        value_op(vbat_pkg::CMD_DECREMENT, 6'h02, 32'h0000_0001);
        xfer(8'h00, vbat_pkg::RSP_ACK);
        value_op(vbat_pkg::CMD_DECREMENT, 6'h3F, 32'hFFFF_FFF0);
        xfer(8'h07, vbat_pkg::RSP_ACK);
        for (int i = 0; i < 6; i++) begin
            value_op(ops[i % 3], 6'($random(seed)), $random(seed));
            xfer(8'($random(seed) & 63), vbat_pkg::RSP_ACK);
        end
        xfer(8'h09, vbat_pkg::RSP_ACK);
        xchg('{vbat_pkg::CMD_INCREMENT, 8'h40, 8'h00, 8'h00}, 1'b1, 1'b1,
             vbat_pkg::RSP_NAK_ARG);
        xfer(8'h40, vbat_pkg::RSP_NAK_ARG);
        xchg('{8'h30, 8'h01, 8'h00, 8'h00}, 1'b1, 1'b1, vbat_pkg::RSP_NAK_ARG);
        xchg('{vbat_pkg::CMD_RESTORE, 8'h03, 8'h00, 8'h00}, 1'b0, 1'b1,
             vbat_pkg::RSP_NAK_CHECK);
        xchg('{vbat_pkg::CMD_RESTORE, 8'h03, 8'h00}, 1'b1, 1'b1,
             vbat_pkg::RSP_NAK_CHECK);
        xchg('{vbat_pkg::CMD_RESTORE, 8'h03, 8'h00, 8'h00}, 1'b1, 1'b1,
             vbat_pkg::RSP_ACK);
        xchg('{8'h01, 8'h02, 8'h03, 8'h04, 8'h00, 8'h00}, 1'b0, 1'b1,
             vbat_pkg::RSP_NAK_CHECK);
        tally_and_finish();
    end
endmodule : value_block_arith_transfer_tb_top

// >>> verification/vbat_reader_model.sv
// Reader-side model: frames bytes onto the link and times the card's replies
`timescale 1ns/100ps
module vbat_reader_model (
    input wire logic clk,
    input wire logic tx_valid,
    input wire logic [3:0] tx_code,
    output logic link_clk,
    output logic [7:0] link_data,
    output logic link_frame,
    output logic link_crc_ok
);
    int rsp_cnt = 0;
    logic [3:0] rsp_code = 4'h0;
    int rsp_lat = 0;
    realtime t_eof = 0.0;

    initial begin
        link_clk = 1'b0;
        link_data = 8'h00;
        link_frame = 1'b0;
        link_crc_ok = 1'b0;
    end

    // Link clock pulses once per byte and once more after the frame to mark its end, and stands low between frames
    task automatic send(input logic [7:0] q [$], input logic ok);
        foreach (q[i]) begin
            link_data = q[i];
            link_frame = 1'b1;
            #62.5 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
        end
        link_frame = 1'b0;
        link_crc_ok = ok;
        // Released data line shows the inverse, so a stale byte cannot look valid
        link_data = ~link_data;
        #62.5 link_clk = 1'b1;
        t_eof = $realtime;
        #62.5 link_clk = 1'b0;
        link_crc_ok = ~ok;
    endtask : send

    // Reply time is taken from the end-of-frame edge, as the reader measures it
    always @(posedge clk) begin
        if (tx_valid === 1'b1) begin
            rsp_cnt <= rsp_cnt + 1;
            rsp_code <= tx_code;
            rsp_lat <= int'(($realtime - t_eof) / 8.0);
        end
    end
endmodule : vbat_reader_model
